/* verilog/rsim_pkg.sv */
// Package for the resolver encoder-simulation and freeze block.
// Assumes a 10 MHz aclk and an AXI4-Lite register bus with 32-bit data.
package rsim_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int UPDATE_MS = 4;
	localparam int UPDATE_CYCLES = UPDATE_MS * 1000000 / CLK_PERIOD_NS;
	localparam longint FAN_HOLD_S = 10;
	localparam longint FAN_HOLD_CYCLES =
		(FAN_HOLD_S * 64'd1000000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_RATIO = 8'h04;
	localparam logic [7:0] OFS_POS = 8'h08;
	localparam logic [7:0] OFS_DUP_REV = 8'h0C;
	localparam logic [7:0] OFS_DUP_FRAC = 8'h10;
	localparam logic [7:0] OFS_CAP_REV = 8'h14;
	localparam logic [7:0] OFS_CAP_FRAC = 8'h18;
	localparam logic [7:0] OFS_CAP_FLAG = 8'h1C;
	localparam logic [7:0] OFS_READY = 8'h20;
	localparam logic [7:0] OFS_HOLD = 8'h24;
	localparam logic [7:0] OFS_FAULT = 8'h28;

	// ****************************************
	// Field encodings and values
	// ****************************************
	localparam logic [1:0] SRC_RESOLVER = 2'h1;
	localparam logic [1:0] SRC_ENCODER = 2'h2;
	localparam logic [1:0] RES_14 = 2'h0;
	localparam logic [1:0] RES_12 = 2'h1;
	localparam logic [1:0] RES_10 = 2'h2;
	localparam logic [3:0] POLES_2 = 4'h0;
	// Ratio thresholds in units of 1/10000
	localparam logic [15:0] RATIO_T32 = 16'h0138;
	localparam logic [15:0] RATIO_T16 = 16'h0271;
	localparam logic [15:0] RATIO_T8 = 16'h04E2;
	localparam logic [15:0] RATIO_T4 = 16'h09C4;
	localparam logic [15:0] RATIO_T2 = 16'h1388;
	localparam logic [15:0] RATIO_RESET = 16'h2710;
	localparam logic [2:0] NMOD_RESET = 3'h1;
	localparam logic [7:0] FAULT_OVERTEMP = 8'h4A;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Block state
	// ****************************************
	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] src;
		logic [1:0] res_sel;
		logic [3:0] poles;
		logic [2:0] nmod;
		logic [15:0] ratio;
		logic hold;
		logic [15:0] res_q;
		logic [15:0] frac;
		logic [15:0] rev;
		logic [15:0] cap_frac;
		logic [15:0] cap_rev;
		logic cap_flag;
		logic trig_q;
		logic ready;
		logic [7:0] fault;
		logic fan_full;
		logic [26:0] fan_cnt;
		logic [15:0] unit_cnt;
		logic [2:0] mod_cnt;
		logic sim_a;
		logic sim_b;
		logic sim_z;
	} rsim_state_t;

	localparam rsim_state_t ST_RESET = '{ratio: RATIO_RESET, nmod: NMOD_RESET, default: '0};

endpackage

/* verilog/rsim_top.sv */
// Resolver feedback logic: simulated encoder output, position tracking,
// freeze capture, feedback-ready flag, fault status and over-temperature.
// Assumes resolver angle and temperature levels arrive already digitised
// and synchronous to aclk; registers are reached over AXI4-Lite.
// Summary of operation
// [R1] Resolver source selected: simulated encoder follows resolver position via divider.
// [R2] At 14 bits, ratio maps to dividers 1/32 through 1 by thresholds.
// [R3] 12-bit resolution floors divider at 1/8; 10-bit uses 1/2 or 1.
// [R4] Marker output is high while resolver position is zero.
// [R5] Encoder source selected: drive encoder A, B, Z pass straight through.
// [R6] Pass-through applies no scaling and ignores the ratio.
// [R7] Any other source holds simulated outputs inactive.
// [R8] Duplicate revolution and fraction values always mirror the primary ones.
// [R9] Freeze and position refresh once per 4 ms times module count.
// [R10] Freeze trigger comes from another module, not a pin of ours.
// [R11] Freeze event with flag clear copies position and sets flag.
// [R12] Flag must be cleared by software; further events ignored while set.
// [R13] Freeze capture works only with a 2-pole resolver setting.
// [R14] Feedback-ready flag starts 0, goes 1 on valid feedback, stays.
// [R15] Hold bit set freezes primary revolution count and position.
// [R16] Fault writes nonzero reason code and raises slot error trip.
// [R17] Drive reset clears the fault reason to zero.
// [R18] Above 90 C fan forced full for at least 10 s.
// [R19] Above 100 C drive trips with reason code 74.
// [R20] Position reads as revolutions in 31:16, fraction in 15:0.
// [R21] Revolution counter is a 16-bit wrapping up/down counter.
// [R22] Freeze event is a trigger rising edge sampled per update period.
// [R23] Quadrature A/B change one at a time, order follows direction.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module rsim_top #(
	parameter int unsigned UPD_CYCLES = rsim_pkg::UPDATE_CYCLES,
	parameter longint FAN_CYCLES = rsim_pkg::FAN_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Resolver position
	input wire logic [15:0] resolver_angle,
	input wire logic resolver_valid,
	// Drive encoder port and freeze trigger
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic enc_z,
	input wire logic freeze_trig,
	// Drive and temperature
	input wire logic drive_reset,
	input wire logic temp_over_90,
	input wire logic temp_over_100,
	// Simulated encoder and alarms
	output logic sim_a,
	output logic sim_b,
	output logic sim_z,
	output logic fan_full,
	output logic slot_error_trip
);

	// ****************************************
	// State
	// ****************************************
	rsim_pkg::rsim_state_t st_reg;
	rsim_pkg::rsim_state_t st_next;
	logic tick;
	logic [15:0] res_mask;
	logic [2:0] shift;
	logic [13:0] sim_cnt;
	logic [15:0] step;
	logic [31:0] rd;
	logic wr_do;

	// Handshake readies are combinational from state
	assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
	assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign sim_a = st_reg.sim_a;
	assign sim_b = st_reg.sim_b;
	assign sim_z = st_reg.sim_z;
	assign fan_full = st_reg.fan_full;
	assign slot_error_trip = st_reg.fault != 8'h00; // see [R16]

	// Update period ends when every installed module has had its slot
	assign tick = (st_reg.unit_cnt == 16'(UPD_CYCLES - 1)) &&
		(st_reg.mod_cnt + 3'h1 >= st_reg.nmod); // see [R9]

	// ****************************************
	// Read data selection
	// ****************************************
	always_comb begin
		rd = 32'h0000_0000;
		if (s_axi_araddr == rsim_pkg::OFS_CFG) begin
			rd = {21'h0, st_reg.nmod, st_reg.poles, st_reg.res_sel, st_reg.src};
		end else if (s_axi_araddr == rsim_pkg::OFS_RATIO) begin
			rd = {16'h0, st_reg.ratio};
		end else if (s_axi_araddr == rsim_pkg::OFS_POS) begin
			rd = {st_reg.rev, st_reg.frac}; // see [R20]
		end else if (s_axi_araddr == rsim_pkg::OFS_DUP_REV) begin
			rd = {16'h0, st_reg.rev}; // see [R8]
		end else if (s_axi_araddr == rsim_pkg::OFS_DUP_FRAC) begin
			rd = {16'h0, st_reg.frac}; // see [R8]
		end else if (s_axi_araddr == rsim_pkg::OFS_CAP_REV) begin
			rd = {16'h0, st_reg.cap_rev};
		end else if (s_axi_araddr == rsim_pkg::OFS_CAP_FRAC) begin
			rd = {16'h0, st_reg.cap_frac};
		end else if (s_axi_araddr == rsim_pkg::OFS_CAP_FLAG) begin
			rd = {31'h0, st_reg.cap_flag};
		end else if (s_axi_araddr == rsim_pkg::OFS_READY) begin
			rd = {31'h0, st_reg.ready};
		end else if (s_axi_araddr == rsim_pkg::OFS_HOLD) begin
			rd = {31'h0, st_reg.hold};
		end else if (s_axi_araddr == rsim_pkg::OFS_FAULT) begin
			rd = {24'h0, st_reg.fault};
		end
	end

	// ****************************************
	// Divider selection and quadrature
	// ****************************************
	// Low-resolution modes drop the lower angle bits, so the masked
	// angle is what both the marker and the counters see.
	always_comb begin
		res_mask = 16'hFFFC;
		if (st_reg.res_sel == rsim_pkg::RES_12) begin
			res_mask = 16'hFFF0;
		end else if (st_reg.res_sel == rsim_pkg::RES_10) begin
			res_mask = 16'hFFC0;
		end
		if (st_reg.ratio <= rsim_pkg::RATIO_T32) begin // see [R2]
			shift = 3'h5;
		end else if (st_reg.ratio <= rsim_pkg::RATIO_T16) begin
			shift = 3'h4;
		end else if (st_reg.ratio <= rsim_pkg::RATIO_T8) begin
			shift = 3'h3;
		end else if (st_reg.ratio <= rsim_pkg::RATIO_T4) begin
			shift = 3'h2;
		end else if (st_reg.ratio <= rsim_pkg::RATIO_T2) begin
			shift = 3'h1;
		end else begin
			shift = 3'h0;
		end
		// Coarser resolvers cannot support the finest dividers
		if (st_reg.res_sel == rsim_pkg::RES_12 && shift > 3'h3) begin
			shift = 3'h3; // see [R3]
		end else if (st_reg.res_sel == rsim_pkg::RES_10 && shift != 3'h0) begin
			shift = 3'h1; // see [R3]
		end
		sim_cnt = st_reg.res_q[15:2] >> shift; // see [R1]
	end

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		st_next = st_reg;
		wr_do = st_reg.aw_got && st_reg.w_got;
		step = 16'h0000;

		// Bus: capture address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_got = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd;
			st_next.rresp = rsim_pkg::RESP_OKAY;
			if (s_axi_araddr > rsim_pkg::OFS_FAULT || s_axi_araddr[1:0] != 2'h0) begin
				st_next.rresp = rsim_pkg::RESP_SLVERR;
			end
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end

		// Register write once both halves are in
		if (wr_do) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = rsim_pkg::RESP_OKAY;
			if (st_reg.aw_addr == rsim_pkg::OFS_CFG) begin
				if (st_reg.w_strb[0]) begin
					st_next.src = st_reg.w_data[1:0];
					st_next.res_sel = st_reg.w_data[3:2];
					st_next.poles = st_reg.w_data[7:4];
				end
				if (st_reg.w_strb[1]) begin
					st_next.nmod = st_reg.w_data[10:8];
				end
			end else if (st_reg.aw_addr == rsim_pkg::OFS_RATIO) begin
				if (st_reg.w_strb[0]) begin
					st_next.ratio[7:0] = st_reg.w_data[7:0];
				end
				if (st_reg.w_strb[1]) begin
					st_next.ratio[15:8] = st_reg.w_data[15:8];
				end
			end else if (st_reg.aw_addr == rsim_pkg::OFS_CAP_FLAG) begin
				if (st_reg.w_strb[0]) begin
					st_next.cap_flag = st_reg.w_data[0]; // see [R12]
				end
			end else if (st_reg.aw_addr == rsim_pkg::OFS_HOLD) begin
				if (st_reg.w_strb[0]) begin
					st_next.hold = st_reg.w_data[0];
				end
			end else if (st_reg.aw_addr < rsim_pkg::OFS_HOLD + 8'h08
				&& st_reg.aw_addr[1:0] == 2'h0) begin
				st_next.bresp = rsim_pkg::RESP_OKAY; // Read-only: write ignored
			end else begin
				st_next.bresp = rsim_pkg::RESP_SLVERR;
			end
		end

		// Update period counters; zero modules is treated as one
		st_next.unit_cnt = st_reg.unit_cnt + 16'h0001;
		if (st_reg.unit_cnt == 16'(UPD_CYCLES - 1)) begin
			st_next.unit_cnt = 16'h0000;
			st_next.mod_cnt = tick ? 3'h0 : st_reg.mod_cnt + 3'h1;
		end

		// Resolver angle sampled every cycle; feedback ready is sticky
		st_next.res_q = resolver_angle & res_mask;
		if (resolver_valid) begin
			st_next.ready = 1'b1; // see [R14]
		end

		if (tick) begin
			// One trigger sample per period, so one capture at most
			st_next.trig_q = freeze_trig; // see [R10] see [R22]
			if (freeze_trig && !st_reg.trig_q && !st_reg.cap_flag
				&& st_reg.poles == rsim_pkg::POLES_2) begin // see [R13]
				st_next.cap_rev = st_reg.rev; // see [R11]
				st_next.cap_frac = st_reg.frac;
				st_next.cap_flag = 1'b1; // Set wins over a same-cycle clear
			end
			// Signed step decides wrap direction across a revolution
			step = st_reg.res_q - st_reg.frac;
			if (!st_reg.hold) begin // see [R15]
				st_next.frac = st_reg.res_q;
				if (!step[15] && step != 16'h0000 && st_reg.res_q < st_reg.frac) begin
					st_next.rev = st_reg.rev + 16'h0001; // see [R21]
				end else if (step[15] && st_reg.res_q > st_reg.frac) begin
					st_next.rev = st_reg.rev - 16'h0001; // see [R21]
				end
			end
		end

		// Fault: over-temperature load wins over a drive reset
		if (drive_reset) begin
			st_next.fault = 8'h00; // see [R17]
		end
		if (temp_over_100) begin
			st_next.fault = rsim_pkg::FAULT_OVERTEMP; // see [R16] see [R19]
		end

		// Fan: retrigger while hot, release after the minimum hold
		if (temp_over_90) begin
			st_next.fan_full = 1'b1; // see [R18]
			st_next.fan_cnt = 27'(FAN_CYCLES - 1);
		end else if (st_reg.fan_cnt != 27'h0) begin
			st_next.fan_cnt = st_reg.fan_cnt - 27'h1;
		end else begin
			st_next.fan_full = 1'b0; // see [R18]
		end

		// Simulated encoder outputs, registered
		st_next.sim_a = 1'b0; // see [R7]
		st_next.sim_b = 1'b0;
		st_next.sim_z = 1'b0;
		if (st_reg.src == rsim_pkg::SRC_RESOLVER) begin
			st_next.sim_a = sim_cnt[1]; // see [R23]
			st_next.sim_b = sim_cnt[1] ^ sim_cnt[0];
			st_next.sim_z = st_reg.res_q == 16'h0000; // see [R4]
		end else if (st_reg.src == rsim_pkg::SRC_ENCODER) begin
			st_next.sim_a = enc_a; // see [R5] see [R6]
			st_next.sim_b = enc_b;
			st_next.sim_z = enc_z;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= rsim_pkg::ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_freeze_evt;
		tick && freeze_trig && !st_reg.trig_q && !st_reg.cap_flag
			&& st_reg.poles == rsim_pkg::POLES_2;
	endsequence

	sequence s_captured;
		st_reg.cap_flag && st_reg.cap_frac == $past(st_reg.frac);
	endsequence

	AST_MARKER: assert property (st_reg.src == rsim_pkg::SRC_RESOLVER && st_reg.res_q == 16'h0000
		|=> sim_z) else $error("marker missing at zero angle"); // see [R4]
	AST_INACTIVE: assert property (st_reg.src != rsim_pkg::SRC_RESOLVER
		&& st_reg.src != rsim_pkg::SRC_ENCODER |=> !sim_a && !sim_b && !sim_z)
		else $error("simulated output active with no source"); // see [R7]
	AST_PASS: assert property (st_reg.src == rsim_pkg::SRC_ENCODER
		|=> sim_a == $past(enc_a) && sim_b == $past(enc_b) && sim_z == $past(enc_z))
		else $error("encoder pass-through mismatch"); // see [R5]
	AST_CAPTURE: assert property (s_freeze_evt |=> s_captured)
		else $error("freeze event not captured"); // see [R11]
	AST_IGNORE: assert property (st_reg.cap_flag |=> $stable(st_reg.cap_frac))
		else $error("capture overwritten while flag set"); // see [R12]
	AST_POLES: assert property (st_reg.poles != rsim_pkg::POLES_2 && !st_reg.cap_flag
		&& !wr_do |=> !st_reg.cap_flag) else $error("capture with non 2-pole"); // see [R13]
	AST_READY: assert property (st_reg.ready |=> st_reg.ready [*2])
		else $error("feedback ready dropped"); // see [R14]
	AST_HOLD: assert property (st_reg.hold && !wr_do |=> $stable(st_reg.rev) && $stable(st_reg.frac))
		else $error("position moved while held"); // see [R15]
	AST_OVERTEMP: assert property (temp_over_100 |=> st_reg.fault == rsim_pkg::FAULT_OVERTEMP
		&& slot_error_trip) else $error("over-temperature not tripped"); // see [R19]
	AST_DRV_RESET: assert property (drive_reset && !temp_over_100 |=> st_reg.fault == 8'h00)
		else $error("fault not cleared by drive reset"); // see [R17]
	AST_FAN: assert property (temp_over_90 |=> fan_full ##1 fan_full)
		else $error("fan not held at full speed"); // see [R18]

endmodule

/* bench/rsim_far_model.sv */
// Far-side model: resolver sensor, drive encoder port and freeze source.
// Assumes the bench commands angle, validity, encoder motion and trigger.
`timescale 1ns/1ps

module rsim_far_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Commands from the bench
	input wire logic [15:0] ang_cmd,
	input wire logic valid_cmd,
	input wire logic enc_run,
	input wire logic trig_cmd,
	// Toward the block
	output logic [15:0] resolver_angle,
	output logic resolver_valid,
	output logic enc_a,
	output logic enc_b,
	output logic enc_z,
	output logic freeze_trig
);
	logic [7:0] enc_pos;
	logic [1:0] enc_div;

	// *****
	// Sensors
	// *****
	// Resolver reports a digital angle word each cycle
	always_ff @(posedge aclk) begin
		resolver_angle <= ang_cmd;
		resolver_valid <= valid_cmd;
		freeze_trig <= trig_cmd; // Trigger comes from a neighbouring module
	end

	// Encoder steps every fourth cycle so each level lasts several samples
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enc_pos <= 8'h00;
			enc_div <= 2'h0;
		end else if (enc_run) begin
			enc_div <= enc_div + 2'h1;
			if (enc_div == 2'h3) begin
				enc_pos <= enc_pos + 8'h01;
			end
		end
	end

	// Clean digital quadrature with a marker once per turn, never sine/cosine
	assign enc_a = enc_pos[1];
	assign enc_b = enc_pos[1] ^ enc_pos[0];
	assign enc_z = (enc_pos == 8'h00);
endmodule

/* bench/rsim_top_tb.sv */
// Self-checking bench for the resolver encoder-simulation block.
// Assumes short update and fan counts; the far-side model drives sensor pins.
`timescale 1ns/1ps

module rsim_top_tb;
	localparam int UPD = 8;
	localparam int FAN = 20;
	// Two modules installed, so the update period is twice the base count
	localparam logic [31:0] CFG_POS = 32'h00000201;
	localparam logic [15:0] RT [8] = '{16'h0138, 16'h0139, 16'h0271, 16'h04E2,
		16'h09C4, 16'h1388, 16'h1389, 16'h7530};
	localparam logic [15:0] WALK [9] = '{16'h5000, 16'hA000, 16'hF000, 16'h4000,
		16'hF000, 16'hA000, 16'h5000, 16'h0000, 16'hB000};
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, pos_exp, cap;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, res;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] resolver_angle, ang_cmd, ang, ratio, dstep;
	logic resolver_valid, valid_cmd, enc_run, trig_cmd, enc_a, enc_b, enc_z, freeze_trig;
	logic drive_reset, temp_over_90, temp_over_100, sim_a, sim_b, sim_z, fan_full;
	logic slot_error_trip;
	logic [2:0] prev;
	integer seed;
	int n_mismatch = 0;
	int cmp_count = 0;

	rsim_top #(.UPD_CYCLES(UPD), .FAN_CYCLES(FAN)) rsim_top_i (.*);
	rsim_far_model rsim_far_model_i (.aclk(aclk), .aresetn(aresetn), .ang_cmd(ang_cmd),
		.valid_cmd(valid_cmd), .enc_run(enc_run), .trig_cmd(trig_cmd),
		.resolver_angle(resolver_angle), .resolver_valid(resolver_valid), .enc_a(enc_a),
		.enc_b(enc_b), .enc_z(enc_z), .freeze_trig(freeze_trig));

	// *****
	// Helpers
	// *****
	// Clock at 10 MHz
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Write; an edge passes first so valid is never driven twice in one step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
		logic aw_p;
		logic w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw_p || w_p) begin
			@(posedge aclk);
			if (aw_p && s_axi_awready) begin
				aw_p = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_p && s_axi_wready) begin
				w_p = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a, d, r);
		chk(name, d, exp);
		chk("read_resp", {30'h0, r}, {30'h0, rsim_pkg::RESP_OKAY});
	endtask

	// Just under two update periods with two modules, enough for the angle to reach every register
	task automatic tick_wait();
		repeat (3 * UPD + 6) @(posedge aclk);
	endtask

	// Move the resolver and track the expected wrapped position
	task automatic mv(input logic [15:0] a);
		ang = a;
		ang_cmd <= a;
		tick_wait();
		dstep = (a & 16'hFFFC) - pos_exp[15:0];
		pos_exp = pos_exp + {{16{dstep[15]}}, dstep};
	endtask

	task automatic trig_pulse();
		trig_cmd <= 1'b0;
		tick_wait();
		trig_cmd <= 1'b1;
		tick_wait();
	endtask

	function automatic logic [2:0] exp_sim(input logic [15:0] a, input logic [1:0] rs,
		input logic [15:0] rt);
		logic [15:0] m;
		logic [13:0] c;
		int sh;
		m = (rs == rsim_pkg::RES_12) ? (a & 16'hFFF0) : (a & 16'hFFFC);
		m = (rs == rsim_pkg::RES_10) ? (a & 16'hFFC0) : m;
		sh = (rt <= rsim_pkg::RATIO_T32) ? 5 : (rt <= rsim_pkg::RATIO_T16) ? 4 :
			(rt <= rsim_pkg::RATIO_T8) ? 3 : (rt <= rsim_pkg::RATIO_T4) ? 2 :
			(rt <= rsim_pkg::RATIO_T2) ? 1 : 0;
		sh = (rs == rsim_pkg::RES_12 && sh > 3) ? 3 : sh;
		sh = (rs == rsim_pkg::RES_10 && sh != 0) ? 1 : sh;
		c = m[15:2] >> sh;
		return {c[1], c[1] ^ c[0], m == 16'h0000};
	endfunction

	// Watchdog cuts a hang short well past the expected run length
	initial begin
		repeat (40000) @(posedge aclk);
		n_mismatch++;
		wrap_up();
	end

	// *****
	// Scenarios
	// *****
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ang_cmd, pos_exp} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{valid_cmd, enc_run, trig_cmd, drive_reset, temp_over_90, temp_over_100} = '0;
		s_axi_wstrb = 4'hF;
		seed = 32'h7A176905;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("ratio_reset", rsim_pkg::OFS_RATIO, 32'h00002710);
		rchk("ready_reset", rsim_pkg::OFS_READY, 32'h0);
		rchk("fault_reset", rsim_pkg::OFS_FAULT, 32'h0);
		axi_rd(8'h2C, d, r);
		chk("unmapped", {r, d[29:0]}, {rsim_pkg::RESP_SLVERR, 30'h0});
		axi_wr(8'h2C, 32'h0, r);
		chk("unmapped_wr", {30'h0, r}, {30'h0, rsim_pkg::RESP_SLVERR});
		axi_wr(rsim_pkg::OFS_POS, 32'hFFFFFFFF, r);
		chk("ro_wr_resp", {30'h0, r}, {30'h0, rsim_pkg::RESP_OKAY});
		rchk("pos_ro", rsim_pkg::OFS_POS, 32'h0);
		// Single lane write must leave the upper ratio byte alone
		s_axi_wstrb <= 4'h1;
		axi_wr(rsim_pkg::OFS_RATIO, 32'h000000AB, r);
		s_axi_wstrb <= 4'hF;
		rchk("ratio_lane", rsim_pkg::OFS_RATIO, {16'h0, rsim_pkg::RATIO_RESET[15:8], 8'hAB});
		valid_cmd <= 1'b1;
		repeat (4) @(posedge aclk);
		valid_cmd <= 1'b0;
		rchk("ready_sticky", rsim_pkg::OFS_READY, 32'h1);
		// Resolver source over every resolution and ratio band
		for (int i = 0; i < 32; i++) begin
			res = i[4:3];
			ratio = (i % 8 == 7) ? 16'($random(seed)) : RT[i % 8];
			ang = (i % 5 == 0) ? 16'h0000 : 16'($random(seed));
			axi_wr(rsim_pkg::OFS_CFG, {21'h0, 3'h1, 4'h0, res, rsim_pkg::SRC_RESOLVER}, r);
			axi_wr(rsim_pkg::OFS_RATIO, {16'h0, ratio}, r);
			ang_cmd <= ang;
			repeat (6) @(posedge aclk);
			chk("sim_abz", {29'h0, sim_a, sim_b, sim_z}, {29'h0, exp_sim(ang, res, ratio)});
		end
		// Pass-through with a random ratio, then inactive sources
		axi_wr(rsim_pkg::OFS_CFG, {30'h0, rsim_pkg::SRC_ENCODER}, r);
		enc_run <= 1'b1;
		@(posedge aclk);
		prev = {enc_a, enc_b, enc_z};
		for (int i = 0; i < 40; i++) begin
			@(posedge aclk);
			chk("pass_abz", {29'h0, sim_a, sim_b, sim_z}, {29'h0, prev});
			prev = {enc_a, enc_b, enc_z};
		end
		ang_cmd <= 16'h0000;
		for (int s = 0; s < 4; s += 3) begin
			axi_wr(rsim_pkg::OFS_CFG, {30'h0, s[1:0]}, r);
			repeat (6) @(posedge aclk);
			chk("idle_abz", {29'h0, sim_a, sim_b, sim_z}, 32'h0);
		end
		// Second reset, then position walk with wraps both ways
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axi_wr(rsim_pkg::OFS_CFG, CFG_POS, r);
		for (int i = 0; i < 14; i++) begin
			mv((i < 9) ? WALK[i] : ang + {{4{seed[11]}}, 12'($random(seed))});
			rchk("pos", rsim_pkg::OFS_POS, pos_exp);
			rchk("dup_rev", rsim_pkg::OFS_DUP_REV, {16'h0, pos_exp[31:16]});
			rchk("dup_frac", rsim_pkg::OFS_DUP_FRAC, {16'h0, pos_exp[15:0]});
		end
		axi_wr(rsim_pkg::OFS_HOLD, 32'h1, r);
		ang_cmd <= ang + 16'h2000;
		tick_wait();
		rchk("pos_held", rsim_pkg::OFS_POS, pos_exp);
		axi_wr(rsim_pkg::OFS_HOLD, 32'h0, r);
		mv(ang + 16'h2000);
		rchk("pos_free", rsim_pkg::OFS_POS, pos_exp);
		// Freeze capture, sticky flag, clear, and pole gating
		trig_pulse();
		cap = pos_exp;
		rchk("cap_flag", rsim_pkg::OFS_CAP_FLAG, 32'h1);
		mv(ang + 16'h1000);
		trig_pulse();
		rchk("cap_frac", rsim_pkg::OFS_CAP_FRAC, {16'h0, cap[15:0]});
		rchk("cap_rev", rsim_pkg::OFS_CAP_REV, {16'h0, cap[31:16]});
		axi_wr(rsim_pkg::OFS_CAP_FLAG, 32'h0, r); // Controller releases the flag
		rchk("cap_clr", rsim_pkg::OFS_CAP_FLAG, 32'h0);
		trig_pulse();
		rchk("cap_again", rsim_pkg::OFS_CAP_FRAC, {16'h0, pos_exp[15:0]});
		axi_wr(rsim_pkg::OFS_CAP_FLAG, 32'h0, r);
		axi_wr(rsim_pkg::OFS_CFG, CFG_POS | 32'h10, r);
		trig_pulse();
		rchk("cap_poles", rsim_pkg::OFS_CAP_FLAG, 32'h0);
		// Over-temperature trip beats drive reset, then reset clears it
		temp_over_100 <= 1'b1;
		drive_reset <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("trip_on", {31'h0, slot_error_trip}, 32'h1);
		rchk("fault_hot", rsim_pkg::OFS_FAULT, {24'h0, rsim_pkg::FAULT_OVERTEMP});
		temp_over_100 <= 1'b0;
		repeat (3) @(posedge aclk);
		drive_reset <= 1'b0;
		chk("trip_off", {31'h0, slot_error_trip}, 32'h0);
		rchk("fault_clr", rsim_pkg::OFS_FAULT, 32'h0);
		// Fan forced full, held the whole minimum span after cooling, then released
		temp_over_90 <= 1'b1;
		repeat (2) @(posedge aclk);
		temp_over_90 <= 1'b0;
		repeat (FAN) @(posedge aclk);
		chk("fan_hold", {31'h0, fan_full}, 32'h1);
		repeat (6) @(posedge aclk);
		chk("fan_free", {31'h0, fan_full}, 32'h0);
		wrap_up();
	end
endmodule
